//--- rtl/aps_pkg.sv
/*
 * Constants, types and decode helpers for the paged auxiliary pin-select
 * register bank.
 * Assumes an 8-bit special-function register bus driven by the CPU on the
 * system clock.
 */
package aps_pkg;

	// special-function addresses
	localparam logic [7:0] AUX_ADDR = 8'ha4;
	localparam logic [7:0] PAGE_ADDR = 8'hac;
	localparam logic [7:0] SHARED_ADDR = 8'ha9;

	// pages owned by this bank at the auxiliary address
	localparam logic [3:0] PAGE_P6 = 4'h7;
	localparam logic [3:0] PAGE_ROUTE11 = 4'h8;
	localparam logic [3:0] PAGE_CRC = 4'h9;
	localparam logic [3:0] PAGE_PWM = 4'hd;
	localparam logic [3:0] PAGE_ARRAY = 4'he;

	// implemented-bit masks; everything else is reserved and reads zero
	localparam logic [7:0] P6_MASK = 8'h07;
	localparam logic [7:0] ROUTE11_MASK = 8'h3b;
	localparam logic [7:0] CRC_MASK = 8'hfc;
	localparam logic [7:0] PWM_MASK = 8'h3f;
	localparam logic [7:0] ARRAY_MASK = 8'h03;
	localparam logic [7:0] PAGE_MASK = 8'h0f;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// field positions
	localparam int P6_FAST_BIT = 0;
	localparam int P6_CKSEL_LSB = 1;
	localparam int TWI1_LSB = 4;
	localparam int RX1_OVR_BIT = 3;
	localparam int T1_CKOE_BIT = 1;
	localparam int T0_CKOE_BIT = 0;
	localparam int CRC_DS2_BIT = 7;
	localparam int CRC_POLY_BIT = 6;
	localparam int TXOE_LSB = 4;
	localparam int CODER_DIR_BIT = 3;
	localparam int SHARED_BIT = 2;
	localparam int PAGE_NUM_LSB = 0;

	// channel counts
	localparam int PWM_CHANNELS = 6;
	localparam int ARRAY_CHANNELS = 2;

	// clock-output code when the pin is a plain port bit
	localparam logic [1:0] CKSEL_GPIO = 2'h0;

	// crc polynomials
	localparam logic [31:0] CRC16_POLY = 32'h0000_1021;
	localparam logic [31:0] CRC32_POLY = 32'h04c1_1db7;

	// which register the current page places at the auxiliary address
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_P6 = 3'b001,
		SEL_ROUTE11 = 3'b010,
		SEL_CRC = 3'b011,
		SEL_PWM = 3'b100,
		SEL_ARRAY = 3'b101
	} aps_reg_sel_type;

	// page number to register select, shared by write and read paths
	function automatic aps_reg_sel_type aps_page_target(input logic [3:0] pg);
		aps_page_target = SEL_NONE;
		unique case (pg)
			PAGE_P6: aps_page_target = SEL_P6;
			PAGE_ROUTE11: aps_page_target = SEL_ROUTE11;
			PAGE_CRC: aps_page_target = SEL_CRC;
			PAGE_PWM: aps_page_target = SEL_PWM;
			PAGE_ARRAY: aps_page_target = SEL_ARRAY;
			default: aps_page_target = SEL_NONE;
		endcase
	endfunction

	// two-bit pin code to one-hot pin ownership
	function automatic logic [3:0] aps_onehot4(input logic [1:0] code);
		aps_onehot4 = 4'h1 << code;
	endfunction

endpackage

//--- rtl/aps_route_if.sv
/*
 * Carrier between the bank and a channel router: per-channel pin choice,
 * channel signals in, and the two candidate pin drives out.
 * Assumes both ends agree on the channel count N.
 */
`timescale 1ns/1ps
interface aps_route_if #(parameter int N = 1);
	logic [N-1:0] sel;
	logic [N-1:0] chan;
	logic [N-1:0] primary;
	logic [N-1:0] alternate;

	modport route (input sel, input chan, output primary, output alternate);
	modport user (output sel, output chan, input primary, input alternate);
endinterface

//--- rtl/aps_channel_route.sv
/*
 * Routes each channel of a timer output group to its first or its
 * alternate port pin.
 * Assumes sel is a stable register bit; the unused pin is held low.
 */
`timescale 1ns/1ps
module aps_channel_route #(parameter int N = 1) (
	aps_route_if.route rt
);

	// one steering cell per channel; bit n only steers channel n
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_chan
			assign rt.primary[i] = rt.chan[i] & ~rt.sel[i];
			assign rt.alternate[i] = rt.chan[i] & rt.sel[i];
		end
	endgenerate

endmodule

//--- rtl/aps_shared_addr.sv
/*
 * Steers CPU accesses at the shared special-function address to either
 * the slave-address register or the 4b/5b coder.
 * Assumes rd and wr are one-cycle strobes qualified with addr.
 */
`timescale 1ns/1ps
module aps_shared_addr (
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic target,
	output logic slave_sel,
	output logic coder_sel
);

	logic hit;

	// only one owner ever sees the access
	always_comb begin
		hit = (addr == aps_pkg::SHARED_ADDR) && (rd || wr);
		slave_sel = hit && !target;
		coder_sel = hit && target;
	end

endmodule

//--- rtl/aps_pin_select_bank.sv
/*
 * Paged auxiliary pin-select register bank: page index register, five
 * auxiliary registers behind one paged address, and the pin routing
 * they steer.
 * Assumes a single CPU on SYS_CLK with one-cycle read and write strobes;
 * peripheral and pin signals are synchronous to SYS_CLK.
 */
`timescale 1ns/1ps
module aps_pin_select_bank (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	output logic [3:0] PAGE_NUMBER,
	output logic SLAVE_ADDRESS_SEL,
	output logic FOUR_FIVE_CODER_SEL,
	input wire logic RC_CLOCK_SELECTED,
	output logic P6_FAST_DRIVE,
	output logic [1:0] P6_CLOCK_OUT_SELECT,
	output logic [3:0] TWI1_PIN_ROUTE,
	input wire logic RXD1_PIN_IN,
	input wire logic COMPARATOR0_OUTPUT,
	output logic RXD1_IN,
	input wire logic TIMER0_CLKOUT,
	input wire logic TIMER1_CLKOUT,
	output logic TIMER0_CLKOUT_PIN,
	output logic TIMER0_CLKOUT_OE_B,
	output logic TIMER1_CLKOUT_PIN,
	output logic TIMER1_CLKOUT_OE_B,
	output logic CRC_DATA_SOURCE_BIT2,
	output logic CRC_POLY_SELECT,
	output logic [31:0] CRC_POLYNOMIAL,
	input wire logic TX_OUTPUT_ENABLE,
	output logic [3:0] TX_ENABLE_PIN,
	output logic CODER_DIRECTION,
	input wire logic [5:0] PWM_CHANNEL_OUTPUT,
	output logic [5:0] PWM_PRIMARY_PIN,
	output logic [5:0] PWM_ALTERNATE_PIN,
	input wire logic [1:0] ARRAY_CHANNEL_OUTPUT,
	output logic [1:0] ARRAY_P6_PIN,
	output logic [1:0] ARRAY_P3_PIN
);

	logic [7:0] page_index;
	logic [7:0] aux_p6_clock_ctrl;
	logic [7:0] aux_pin_route_11;
	logic [7:0] aux_crc_coder_ctrl;
	logic [7:0] aux_pwm_out_route;
	logic [7:0] aux_array_out_route;
	logic [7:0] rdata;
	logic [7:0] next_page_index;
	logic [7:0] next_aux_p6_clock_ctrl;
	logic [7:0] next_aux_pin_route_11;
	logic [7:0] next_aux_crc_coder_ctrl;
	logic [7:0] next_aux_pwm_out_route;
	logic [7:0] next_aux_array_out_route;
	logic [7:0] next_rdata;
	logic aux_wr;
	logic aux_rd;
	aps_pkg::aps_reg_sel_type target;

	aps_route_if #(.N(aps_pkg::PWM_CHANNELS)) pwm_if ();
	aps_route_if #(.N(aps_pkg::ARRAY_CHANNELS)) array_if ();

	// page decode: the same function drives writes and read-back
	always_comb begin
		target = aps_pkg::aps_page_target(page_index[3:0]);
		aux_wr = SFR_WR && (SFR_ADDR == aps_pkg::AUX_ADDR);
		aux_rd = SFR_RD && (SFR_ADDR == aps_pkg::AUX_ADDR);
	end

	// register writes; reserved bits are masked so stray ones never route
	always_comb begin
		next_page_index = page_index;
		next_aux_p6_clock_ctrl = aux_p6_clock_ctrl;
		next_aux_pin_route_11 = aux_pin_route_11;
		next_aux_crc_coder_ctrl = aux_crc_coder_ctrl;
		next_aux_pwm_out_route = aux_pwm_out_route;
		next_aux_array_out_route = aux_array_out_route;
		if (SFR_WR && (SFR_ADDR == aps_pkg::PAGE_ADDR)) begin
			next_page_index = SFR_WDATA & aps_pkg::PAGE_MASK;
		end
		if (aux_wr) begin
			unique case (target)
				aps_pkg::SEL_P6: begin
					next_aux_p6_clock_ctrl = SFR_WDATA & aps_pkg::P6_MASK;
				end
				aps_pkg::SEL_ROUTE11: begin
					next_aux_pin_route_11 = SFR_WDATA & aps_pkg::ROUTE11_MASK;
				end
				aps_pkg::SEL_CRC: begin
					next_aux_crc_coder_ctrl = SFR_WDATA & aps_pkg::CRC_MASK;
				end
				aps_pkg::SEL_PWM: begin
					next_aux_pwm_out_route = SFR_WDATA & aps_pkg::PWM_MASK;
				end
				aps_pkg::SEL_ARRAY: begin
					next_aux_array_out_route = SFR_WDATA & aps_pkg::ARRAY_MASK;
				end
				aps_pkg::SEL_NONE: begin
					next_page_index = next_page_index; // other pages live elsewhere
				end
			endcase
		end
	end

	// read-back, one cycle after the strobe; unowned pages read zero
	always_comb begin
		next_rdata = aps_pkg::READ_IDLE;
		if (SFR_RD && (SFR_ADDR == aps_pkg::PAGE_ADDR)) begin
			next_rdata = page_index;
		end else if (aux_rd) begin
			unique case (target)
				aps_pkg::SEL_P6: next_rdata = aux_p6_clock_ctrl;
				aps_pkg::SEL_ROUTE11: next_rdata = aux_pin_route_11;
				aps_pkg::SEL_CRC: next_rdata = aux_crc_coder_ctrl;
				aps_pkg::SEL_PWM: next_rdata = aux_pwm_out_route;
				aps_pkg::SEL_ARRAY: next_rdata = aux_array_out_route;
				aps_pkg::SEL_NONE: next_rdata = aps_pkg::READ_IDLE;
			endcase
		end
	end

	// all registers clear on reset so every pin starts on its default route
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			page_index <= aps_pkg::REG_RESET;
			aux_p6_clock_ctrl <= aps_pkg::REG_RESET;
			aux_pin_route_11 <= aps_pkg::REG_RESET;
			aux_crc_coder_ctrl <= aps_pkg::REG_RESET;
			aux_pwm_out_route <= aps_pkg::REG_RESET;
			aux_array_out_route <= aps_pkg::REG_RESET;
			rdata <= aps_pkg::READ_IDLE;
		end else begin
			page_index <= next_page_index;
			aux_p6_clock_ctrl <= next_aux_p6_clock_ctrl;
			aux_pin_route_11 <= next_aux_pin_route_11;
			aux_crc_coder_ctrl <= next_aux_crc_coder_ctrl;
			aux_pwm_out_route <= next_aux_pwm_out_route;
			aux_array_out_route <= next_aux_array_out_route;
			rdata <= next_rdata;
		end
	end

	assign SFR_RDATA = rdata;
	assign PAGE_NUMBER = page_index[aps_pkg::PAGE_NUM_LSB +: 4];

	// shared address steering
	aps_shared_addr u_shared (
		.addr(SFR_ADDR),
		.rd(SFR_RD),
		.wr(SFR_WR),
		.target(aux_crc_coder_ctrl[aps_pkg::SHARED_BIT]),
		.slave_sel(SLAVE_ADDRESS_SEL),
		.coder_sel(FOUR_FIVE_CODER_SEL)
	);

	// p6.0 drive and clock-out; the clock generator itself sits elsewhere
	// and is told the effective code, so a crystal never sees a clock out
	always_comb begin
		P6_FAST_DRIVE = aux_p6_clock_ctrl[aps_pkg::P6_FAST_BIT];
		P6_CLOCK_OUT_SELECT = aps_pkg::CKSEL_GPIO;
		if (RC_CLOCK_SELECTED) begin
			P6_CLOCK_OUT_SELECT = aux_p6_clock_ctrl[aps_pkg::P6_CKSEL_LSB +: 2];
		end
	end

	// two-wire, receive and timer clock-out routing
	always_comb begin
		TWI1_PIN_ROUTE = aps_pkg::aps_onehot4(
			aux_pin_route_11[aps_pkg::TWI1_LSB +: 2]);
		RXD1_IN = aux_pin_route_11[aps_pkg::RX1_OVR_BIT] ?
			COMPARATOR0_OUTPUT : RXD1_PIN_IN;
		TIMER1_CLKOUT_OE_B = !aux_pin_route_11[aps_pkg::T1_CKOE_BIT];
		TIMER1_CLKOUT_PIN = TIMER1_CLKOUT &&
			aux_pin_route_11[aps_pkg::T1_CKOE_BIT];
		TIMER0_CLKOUT_OE_B = !aux_pin_route_11[aps_pkg::T0_CKOE_BIT];
		TIMER0_CLKOUT_PIN = TIMER0_CLKOUT &&
			aux_pin_route_11[aps_pkg::T0_CKOE_BIT];
	end

	// crc, transmit-enable and coder controls
	always_comb begin
		CRC_DATA_SOURCE_BIT2 = aux_crc_coder_ctrl[aps_pkg::CRC_DS2_BIT];
		CRC_POLY_SELECT = aux_crc_coder_ctrl[aps_pkg::CRC_POLY_BIT];
		CRC_POLYNOMIAL = CRC_POLY_SELECT ?
			aps_pkg::CRC32_POLY : aps_pkg::CRC16_POLY;
		TX_ENABLE_PIN = aps_pkg::aps_onehot4(
			aux_crc_coder_ctrl[aps_pkg::TXOE_LSB +: 2]) &
			{4{TX_OUTPUT_ENABLE}};
		CODER_DIRECTION = aux_crc_coder_ctrl[aps_pkg::CODER_DIR_BIT];
	end

	// channel steering for the pwm timer and the counter array
	assign pwm_if.sel = aux_pwm_out_route[aps_pkg::PWM_CHANNELS-1:0];
	assign pwm_if.chan = PWM_CHANNEL_OUTPUT;
	assign PWM_PRIMARY_PIN = pwm_if.primary;
	assign PWM_ALTERNATE_PIN = pwm_if.alternate;
	assign array_if.sel = aux_array_out_route[aps_pkg::ARRAY_CHANNELS-1:0];
	assign array_if.chan = ARRAY_CHANNEL_OUTPUT;
	assign ARRAY_P6_PIN = array_if.primary;
	assign ARRAY_P3_PIN = array_if.alternate;

	aps_channel_route #(.N(aps_pkg::PWM_CHANNELS)) u_pwm_route (
		.rt(pwm_if.route)
	);

	aps_channel_route #(.N(aps_pkg::ARRAY_CHANNELS)) u_array_route (
		.rt(array_if.route)
	);

	// checks on the register file and routing
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);

	property p_page_write;
		SFR_WR && SFR_ADDR == aps_pkg::PAGE_ADDR |=>
			PAGE_NUMBER == $past(SFR_WDATA[3:0]) && page_index[7:4] == 4'h0;
	endproperty
	a_page_write: assert property (p_page_write)
		else $error("page index not loaded from write");

	property p_route11_write;
		aux_wr && page_index == {4'h0, aps_pkg::PAGE_ROUTE11} |=>
			aux_pin_route_11 ==
			($past(SFR_WDATA) & aps_pkg::ROUTE11_MASK);
	endproperty
	a_route11_write: assert property (p_route11_write)
		else $error("page 8 write not taken with reserved bits cleared");

	property p_off_page_hold;
		aux_wr && page_index != {4'h0, aps_pkg::PAGE_CRC} &&
			!(SFR_WR && SFR_ADDR == aps_pkg::PAGE_ADDR)
			|=> $stable(aux_crc_coder_ctrl);
	endproperty
	a_off_page_hold: assert property (p_off_page_hold)
		else $error("crc control changed by write on another page");

	property p_reserved_read;
		SFR_RD && SFR_ADDR == aps_pkg::AUX_ADDR &&
			page_index == {4'h0, aps_pkg::PAGE_ARRAY}
			|=> (SFR_RDATA & ~aps_pkg::ARRAY_MASK) == 8'h00;
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("reserved bits read back nonzero");

	property p_shared_addr;
		(SFR_RD || SFR_WR) && SFR_ADDR == aps_pkg::SHARED_ADDR |->
			FOUR_FIVE_CODER_SEL ==
			aux_crc_coder_ctrl[aps_pkg::SHARED_BIT] &&
			SLAVE_ADDRESS_SEL ==
			!aux_crc_coder_ctrl[aps_pkg::SHARED_BIT];
	endproperty
	a_shared_addr: assert property (p_shared_addr)
		else $error("shared address went to the wrong target");

	property p_crc_poly;
		aux_wr && page_index == {4'h0, aps_pkg::PAGE_CRC} |=>
			CRC_POLYNOMIAL ==
			($past(SFR_WDATA[aps_pkg::CRC_POLY_BIT]) ?
			aps_pkg::CRC32_POLY : aps_pkg::CRC16_POLY);
	endproperty
	a_crc_poly: assert property (p_crc_poly)
		else $error("crc polynomial does not follow mode bit");

	property p_rx_override;
		aux_pin_route_11[aps_pkg::RX1_OVR_BIT] |->
			RXD1_IN == COMPARATOR0_OUTPUT;
	endproperty
	a_rx_override: assert property (p_rx_override)
		else $error("receive not forced to comparator output");

	property p_timer_clkout;
		TIMER1_CLKOUT_OE_B |-> !TIMER1_CLKOUT_PIN &&
			!aux_pin_route_11[aps_pkg::T1_CKOE_BIT];
	endproperty
	a_timer_clkout: assert property (p_timer_clkout)
		else $error("timer 1 clock out driven while disabled");

	property p_rc_gate;
		!RC_CLOCK_SELECTED |-> P6_CLOCK_OUT_SELECT == aps_pkg::CKSEL_GPIO;
	endproperty
	a_rc_gate: assert property (p_rc_gate)
		else $error("p6.0 clock out selected without rc clock");

	property p_pwm_route;
		(PWM_PRIMARY_PIN & PWM_ALTERNATE_PIN) == 6'h00 &&
			(PWM_PRIMARY_PIN | PWM_ALTERNATE_PIN) == PWM_CHANNEL_OUTPUT;
	endproperty
	a_pwm_route: assert property (p_pwm_route)
		else $error("pwm channel reached both or neither pin");

	property p_twi_route;
		$onehot(TWI1_PIN_ROUTE) &&
			TWI1_PIN_ROUTE[aux_pin_route_11[aps_pkg::TWI1_LSB +: 2]];
	endproperty
	a_twi_route: assert property (p_twi_route)
		else $error("two-wire route does not match its field");

endmodule

//--- test/tb_aps_pin_select_bank.sv
/*
 * Self-checking bench for the paged auxiliary pin-select bank: register
 * access through the bank's own strobes, paging, and every pin route.
 * Assumes the bank is the only responder and that routes are combinational
 * from the registers, so they are sampled a cycle after each write.
 */
`timescale 1ns/1ps
module tb_aps_pin_select_bank;
	logic SYS_CLK, RST_B, SFR_WR, SFR_RD;
	logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
	logic [3:0] PAGE_NUMBER, TWI1_PIN_ROUTE, TX_ENABLE_PIN;
	logic SLAVE_ADDRESS_SEL, FOUR_FIVE_CODER_SEL, RC_CLOCK_SELECTED;
	logic P6_FAST_DRIVE, RXD1_PIN_IN, COMPARATOR0_OUTPUT, RXD1_IN;
	logic [1:0] P6_CLOCK_OUT_SELECT;
	logic TIMER0_CLKOUT, TIMER1_CLKOUT, TIMER0_CLKOUT_PIN, TIMER1_CLKOUT_PIN;
	logic TIMER0_CLKOUT_OE_B, TIMER1_CLKOUT_OE_B, TX_OUTPUT_ENABLE;
	logic CRC_DATA_SOURCE_BIT2, CRC_POLY_SELECT, CODER_DIRECTION;
	logic [31:0] CRC_POLYNOMIAL;
	logic [5:0] PWM_CHANNEL_OUTPUT, PWM_PRIMARY_PIN, PWM_ALTERNATE_PIN;
	logic [1:0] ARRAY_CHANNEL_OUTPUT, ARRAY_P6_PIN, ARRAY_P3_PIN;
	logic [7:0] q;
	logic [3:0] pages [5];
	logic [7:0] masks [5];
	int err_total = 0;
	int n_compared = 0;

	aps_pin_select_bank dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
		.SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
		.SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
		.PAGE_NUMBER(PAGE_NUMBER), .SLAVE_ADDRESS_SEL(SLAVE_ADDRESS_SEL),
		.FOUR_FIVE_CODER_SEL(FOUR_FIVE_CODER_SEL),
		.RC_CLOCK_SELECTED(RC_CLOCK_SELECTED), .P6_FAST_DRIVE(P6_FAST_DRIVE),
		.P6_CLOCK_OUT_SELECT(P6_CLOCK_OUT_SELECT),
		.TWI1_PIN_ROUTE(TWI1_PIN_ROUTE), .RXD1_PIN_IN(RXD1_PIN_IN),
		.COMPARATOR0_OUTPUT(COMPARATOR0_OUTPUT), .RXD1_IN(RXD1_IN),
		.TIMER0_CLKOUT(TIMER0_CLKOUT), .TIMER1_CLKOUT(TIMER1_CLKOUT),
		.TIMER0_CLKOUT_PIN(TIMER0_CLKOUT_PIN),
		.TIMER0_CLKOUT_OE_B(TIMER0_CLKOUT_OE_B),
		.TIMER1_CLKOUT_PIN(TIMER1_CLKOUT_PIN),
		.TIMER1_CLKOUT_OE_B(TIMER1_CLKOUT_OE_B),
		.CRC_DATA_SOURCE_BIT2(CRC_DATA_SOURCE_BIT2),
		.CRC_POLY_SELECT(CRC_POLY_SELECT), .CRC_POLYNOMIAL(CRC_POLYNOMIAL),
		.TX_OUTPUT_ENABLE(TX_OUTPUT_ENABLE), .TX_ENABLE_PIN(TX_ENABLE_PIN),
		.CODER_DIRECTION(CODER_DIRECTION),
		.PWM_CHANNEL_OUTPUT(PWM_CHANNEL_OUTPUT),
		.PWM_PRIMARY_PIN(PWM_PRIMARY_PIN),
		.PWM_ALTERNATE_PIN(PWM_ALTERNATE_PIN),
		.ARRAY_CHANNEL_OUTPUT(ARRAY_CHANNEL_OUTPUT),
		.ARRAY_P6_PIN(ARRAY_P6_PIN), .ARRAY_P3_PIN(ARRAY_P3_PIN));

	// free-running 50 MHz system clock
	initial begin
		SYS_CLK = 1'b0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one comparison kind; narrower results are zero-extended by callers
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// write strobe for one cycle, then an idle cycle so strobes never merge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1'b1;
		@(posedge SYS_CLK);
		#1 SFR_WR = 1'b0;
		@(posedge SYS_CLK);
		#1;
	endtask

	// read data lands one cycle after the strobe and stands for one cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		@(posedge SYS_CLK);
		#1 SFR_RD = 1'b0;
		d = SFR_RDATA;
		@(posedge SYS_CLK);
		#1 chk("rdata idle", 32'h0, 32'(SFR_RDATA));
	endtask

	task automatic set_reg(input logic [3:0] pg, input logic [7:0] d);
		wr(aps_pkg::PAGE_ADDR, {4'h0, pg});
		wr(aps_pkg::AUX_ADDR, d);
	endtask

	// shared-address steering is combinational while the strobe is up
	task automatic probe(input logic [7:0] a, input logic s, input logic c);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		#2 chk("slave sel", 32'(s), 32'(SLAVE_ADDRESS_SEL));
		chk("coder sel", 32'(c), 32'(FOUR_FIVE_CODER_SEL));
		@(posedge SYS_CLK);
		#1 SFR_RD = 1'b0;
		@(posedge SYS_CLK);
		#1;
	endtask

	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#400000;
		err_total++;
		final_report();
	end

	initial begin
		pages = '{aps_pkg::PAGE_P6, aps_pkg::PAGE_ROUTE11, aps_pkg::PAGE_CRC,
			aps_pkg::PAGE_PWM, aps_pkg::PAGE_ARRAY};
		masks = '{aps_pkg::P6_MASK, aps_pkg::ROUTE11_MASK, aps_pkg::CRC_MASK,
			aps_pkg::PWM_MASK, aps_pkg::ARRAY_MASK};
		RST_B = 1'b0;
		SFR_ADDR = 8'h00;
		SFR_WDATA = 8'h00;
		SFR_WR = 1'b0;
		SFR_RD = 1'b0;
		RC_CLOCK_SELECTED = 1'b1;
		RXD1_PIN_IN = 1'b0;
		COMPARATOR0_OUTPUT = 1'b0;
		TIMER0_CLKOUT = 1'b1;
		TIMER1_CLKOUT = 1'b1;
		TX_OUTPUT_ENABLE = 1'b1;
		PWM_CHANNEL_OUTPUT = 6'h3f;
		ARRAY_CHANNEL_OUTPUT = 2'h3;
		repeat (8) @(posedge SYS_CLK);
		#1 RST_B = 1'b1;
		// reset state of the page, two-wire route, timer 0 clock enable and crc polynomial
		chk("page", 32'h0, 32'(PAGE_NUMBER));
		chk("twi route", 32'h1, 32'(TWI1_PIN_ROUTE));
		chk("t0 oe_b", 32'h1, 32'(TIMER0_CLKOUT_OE_B));
		chk("poly", 32'h0000_1021, CRC_POLYNOMIAL);
		// top page; reserved index bits are written as zero and read zero
		wr(aps_pkg::PAGE_ADDR, 8'h0f);
		rd(aps_pkg::PAGE_ADDR, q);
		chk("page index", 32'h0f, 32'(q));
		chk("page out", 32'hf, 32'(PAGE_NUMBER));
		// each owned page answers with its implemented bits only
		// select the page first so the reset read sees its own register
		for (int i = 0; i < 5; i++) begin
			wr(aps_pkg::PAGE_ADDR, {4'h0, pages[i]});
			rd(aps_pkg::AUX_ADDR, q);
			chk("reset value", 32'h0, 32'(q));
			wr(aps_pkg::AUX_ADDR, masks[i]);
			rd(aps_pkg::AUX_ADDR, q);
			chk("aux mask", 32'(masks[i]), 32'(q));
		end
		// a foreign page neither reads nor disturbs the bank
		set_reg(4'h5, 8'h00);
		rd(aps_pkg::AUX_ADDR, q);
		chk("foreign page", 32'h0, 32'(q));
		chk("twi kept", 32'h8, 32'(TWI1_PIN_ROUTE));
		rd(8'h55, q);
		chk("unmapped", 32'h0, 32'(q));
		// second two-wire pins and transmit enable pin, every code
		for (int c = 0; c < 4; c++) begin
			set_reg(aps_pkg::PAGE_ROUTE11, 8'(c << 4));
			chk("twi route", 32'(4'h1 << c), 32'(TWI1_PIN_ROUTE));
			set_reg(aps_pkg::PAGE_CRC, 8'(c << 4));
			chk("tx pin", 32'(4'h1 << c), 32'(TX_ENABLE_PIN));
		end
		TX_OUTPUT_ENABLE = 1'b0;
		@(posedge SYS_CLK);
		#1 chk("tx pin idle", 32'h0, 32'(TX_ENABLE_PIN));
		// receive override follows comparator only when set
		RXD1_PIN_IN = 1'b1;
		set_reg(aps_pkg::PAGE_ROUTE11, 8'h08);
		chk("rx forced", 32'h0, 32'(RXD1_IN));
		COMPARATOR0_OUTPUT = 1'b1;
		RXD1_PIN_IN = 1'b0;
		@(posedge SYS_CLK);
		#1 chk("rx forced", 32'h1, 32'(RXD1_IN));
		set_reg(aps_pkg::PAGE_ROUTE11, 8'h01);
		chk("rx pin", 32'h0, 32'(RXD1_IN));
		// timer clock outputs enabled one at a time
		chk("t0 pin", 32'h1, 32'(TIMER0_CLKOUT_PIN));
		chk("t0 oe_b", 32'h0, 32'(TIMER0_CLKOUT_OE_B));
		chk("t1 oe_b", 32'h1, 32'(TIMER1_CLKOUT_OE_B));
		set_reg(aps_pkg::PAGE_ROUTE11, 8'h02);
		chk("t1 pin", 32'h1, 32'(TIMER1_CLKOUT_PIN));
		chk("t1 oe_b", 32'h0, 32'(TIMER1_CLKOUT_OE_B));
		chk("t0 oe_b", 32'h1, 32'(TIMER0_CLKOUT_OE_B));
		chk("t0 pin", 32'h0, 32'(TIMER0_CLKOUT_PIN));
		// the pin must follow the timer, not just the enable
		TIMER1_CLKOUT = 1'b0;
		@(posedge SYS_CLK);
		#1 chk("t1 pin", 32'h0, 32'(TIMER1_CLKOUT_PIN));
		// crc, coder and shared address controls
		set_reg(aps_pkg::PAGE_CRC, 8'hc8);
		chk("poly", 32'h04c1_1db7, CRC_POLYNOMIAL);
		chk("poly sel", 32'h1, 32'(CRC_POLY_SELECT));
		chk("crc src2", 32'h1, 32'(CRC_DATA_SOURCE_BIT2));
		chk("coder dir", 32'h1, 32'(CODER_DIRECTION));
		probe(aps_pkg::SHARED_ADDR, 1'b1, 1'b0);
		set_reg(aps_pkg::PAGE_CRC, 8'h04);
		chk("coder dir", 32'h0, 32'(CODER_DIRECTION));
		chk("poly", 32'h0000_1021, CRC_POLYNOMIAL);
		probe(aps_pkg::SHARED_ADDR, 1'b0, 1'b1);
		probe(8'ha8, 1'b0, 1'b0);
		// compare outputs and counter-array outputs, per channel
		set_reg(aps_pkg::PAGE_PWM, 8'h2a);
		chk("pwm first", 32'h15, 32'(PWM_PRIMARY_PIN));
		chk("pwm alt", 32'h2a, 32'(PWM_ALTERNATE_PIN));
		PWM_CHANNEL_OUTPUT = 6'h0c;
		@(posedge SYS_CLK);
		#1 chk("pwm first", 32'h04, 32'(PWM_PRIMARY_PIN));
		chk("pwm alt", 32'h08, 32'(PWM_ALTERNATE_PIN));
		set_reg(aps_pkg::PAGE_ARRAY, 8'h01);
		chk("array p6", 32'h2, 32'(ARRAY_P6_PIN));
		chk("array p3", 32'h1, 32'(ARRAY_P3_PIN));
		// clock-out code only with the internal oscillator
		set_reg(aps_pkg::PAGE_P6, 8'h07);
		chk("fast drive", 32'h1, 32'(P6_FAST_DRIVE));
		chk("clk sel", 32'h3, 32'(P6_CLOCK_OUT_SELECT));
		RC_CLOCK_SELECTED = 1'b0;
		@(posedge SYS_CLK);
		#1 chk("clk sel", 32'h0, 32'(P6_CLOCK_OUT_SELECT));
		set_reg(aps_pkg::PAGE_P6, 8'h04);
		chk("fast drive", 32'h0, 32'(P6_FAST_DRIVE));
		// reset in mid-run clears the paged state
		RST_B = 1'b0;
		@(posedge SYS_CLK);
		#1 chk("page", 32'h0, 32'(PAGE_NUMBER));
		chk("array p3", 32'h0, 32'(ARRAY_P3_PIN));
		RST_B = 1'b1;
		@(posedge SYS_CLK);
		#1 final_report();
	end
endmodule
